/* hw/ppd_pkg.sv */
// Purpose: constants for the pulse-per-second discipline block
// Assumes: 40 MHz aclk, AXI4-Lite register access
// Notes:   damping factor is fixed point with 2 fraction bits (quarters)
package ppd_pkg;
    localparam int          CLK_HZ        = 40_000_000;
    localparam int          TICKS_PER_SEC = CLK_HZ;        // internal pulse period
    localparam int          PULSE_NS      = 1000;          // width of local pulse
    localparam int          PULSE_CYC     = (PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // register byte offsets
    localparam logic [7:0]  OFS_CTRL      = 8'h00;  // lock mode
    localparam logic [7:0]  OFS_DAMP      = 8'h04;  // damping factor, quarters
    localparam logic [7:0]  OFS_TAU       = 8'h08;  // time constant, seconds
    localparam logic [7:0]  OFS_DELTA     = 8'h0c;  // captured tick error
    localparam logic [7:0]  OFS_STATE     = 8'h10;  // state code and lock bits
    localparam logic [7:0]  OFS_SAVE      = 8'h14;  // write 1: store coefficients
    // limits and defaults
    localparam logic [4:0]  DAMP_MIN      = 5'h01;  // 0.25
    localparam logic [4:0]  DAMP_MAX      = 5'h10;  // 4.0
    localparam logic [4:0]  DAMP_DEF      = 5'h04;  // 1.0
    localparam logic [16:0] TAU_MIN       = 17'h00005;
    localparam logic [16:0] TAU_MAX       = 17'h186a0; // 100000
    localparam logic [16:0] TAU_DEF       = 17'h00190; // 400
    localparam logic [1:0]  MODE_DEF      = 2'h2;
    localparam logic [31:0] LOCK_WIN      = 32'h00000010; // ticks of error called locked
    // discipline state codes
    localparam logic [3:0]  ST_INIT       = 4'h0;
    localparam logic [3:0]  ST_HOLD       = 4'h3;
    localparam logic [3:0]  ST_JAM        = 4'h4;
    localparam logic [3:0]  ST_DISC       = 4'h6;
    localparam logic [3:0]  ST_CALC       = 4'h7;
    localparam logic [3:0]  ST_UPD        = 4'h8;
    localparam logic [3:0]  ST_SLOPE      = 4'h9;
endpackage : ppd_pkg

/* hw/ppd_discipline.sv */
// Purpose: local 1 pps generation, reference error capture and phase steering
// Assumes: reference pulse asynchronous, width at least two aclk periods
// Notes:   counter steps at aclk; delta is signed ticks, reference minus local
`timescale 1ns/100ps

// How it works
// - local one-second pulse made from the oscillator clock drives pps_out.
// - each reference pulse triggers a measurement against the local pulse.
// - error stored as signed oscillator_ticks in delta register.
// - delta register readable by software as a plain hex word.
// - steering adjusts period and phase; local pulse keeps running without reference.
// - disciplining active straight from reset with no software action.
// - lock mode 1 stops steering to the reference.
// - damping factor clamps between 0.25 and 4.
// - time constant in seconds, 5 to 100000, scales the phase correction.
// - out-of-range time constant restores both defaults.
// - defaults are damping 1 and time constant 400.
// - steering only while the atomic loop reports lock.
// - defaults make the block work with no configuration at all.
// - serial link at 57600 8N1 lives outside; registers replace it here.
// - state code reported: 3 holdover, 4 jam, 6-8 discipline.
// - state register holds state code beside the atomic and pulse lock bits.
// - lock output follows atomic lock, or in mode 2 also pulse lock.
// - save copies coefficients to a kept set; reset loads defaults into both sets.
module ppd_discipline
    import ppd_pkg::*;
#(
    parameter int TICKS = ppd_pkg::TICKS_PER_SEC   // ticks per local second
) (
    input  wire logic        aclk,          // 40 MHz clock
    input  wire logic        aresetn,       // sync reset, low active
    input  wire logic        pps_ref_in,    // reference pulse, asynchronous
    input  wire logic        atomic_lock,   // frequency loop locked
    output logic             pps_out,       // local one-second pulse
    output logic             lock_out,      // lock indication
    input  wire logic [7:0]  s_axi_awaddr,  // write address
    input  wire logic        s_axi_awvalid, // write address valid
    output logic             s_axi_awready, // write address ready
    input  wire logic [31:0] s_axi_wdata,   // write data
    input  wire logic [3:0]  s_axi_wstrb,   // byte enables
    input  wire logic        s_axi_wvalid,  // write data valid
    output logic             s_axi_wready,  // write data ready
    output logic [1:0]       s_axi_bresp,   // write response
    output logic             s_axi_bvalid,  // write response valid
    input  wire logic        s_axi_bready,  // write response ready
    input  wire logic [7:0]  s_axi_araddr,  // read address
    input  wire logic        s_axi_arvalid, // read address valid
    output logic             s_axi_arready, // read address ready
    output logic [31:0]      s_axi_rdata,   // read data
    output logic [1:0]       s_axi_rresp,   // read response
    output logic             s_axi_rvalid,  // read data valid
    input  wire logic        s_axi_rready   // read data ready
);
    import ppd_pkg::*;

    initial begin
        if (TICKS < 4 * PULSE_CYC || TICKS > 32'h7fffffff)
            $error("ppd_discipline: TICKS out of range");
    end

    typedef enum logic [4:0] {
        PH_HOLD = 5'b00001,
        PH_JAM  = 5'b00010,
        PH_DISC = 5'b00100,
        PH_CALC = 5'b01000,
        PH_UPD  = 5'b10000
    } ppd_phase_t;

    typedef struct packed {
        logic        sync1, sync2, sync3;      // reference synchronizer and edge
        logic [31:0] ticks;                    // oscillator_ticks since local pulse
        logic [31:0] period;                   // current steered period
        logic [31:0] delta;                    // captured error, signed
        logic        have_ref;                 // a reference seen since last local pulse
        logic        pulse_lock;
        ppd_phase_t  phase;
        logic [1:0]  mode;
        logic [4:0]  damp;
        logic [16:0] tau;
        logic [4:0]  saved_damp;
        logic [16:0] saved_tau;
        logic        pps_out, lock_out;
        logic        awready, wready, bvalid, arready, rvalid;
        logic [1:0]  bresp, rresp;
        logic [31:0] rdata;
        logic        aw_got, w_got;
        logic [7:0]  aw_addr;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
    } ppd_state_t;

    ppd_state_t st, next_st;

    // signed wrap of capture: late half of second counts as negative
    function automatic logic [31:0] wrap_err(input logic [31:0] t, input logic [31:0] p);
        wrap_err = (t > (p >> 1)) ? t - p : t;
    endfunction : wrap_err

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] b);
        for (int i = 0; i < 4; i++)
            merge[i*8 +: 8] = b[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    endfunction : merge

    function automatic logic [3:0] state_code(input ppd_phase_t p);
        case (p)
            PH_HOLD: state_code = ST_HOLD;
            PH_JAM:  state_code = ST_JAM;
            PH_DISC: state_code = ST_DISC;
            PH_CALC: state_code = ST_CALC;
            PH_UPD:  state_code = ST_UPD;
            default: state_code = ST_INIT;
        endcase
    endfunction : state_code

    logic        ref_edge;
    logic        steer_ok;
    logic [31:0] err_now;
    logic [31:0] corr;
    logic [31:0] wv;
    logic        wr_fire;

    assign ref_edge = st.sync2 & ~st.sync3;
    assign steer_ok = atomic_lock & (st.mode != 2'h1);
    assign err_now  = wrap_err(st.ticks, st.period);
    // correction = error * damping / tau, damping in quarters
    assign corr     = 32'($signed(st.delta) * $signed({1'b0, st.damp})
                          / $signed({15'h0000, st.tau, 2'b00}));
    assign wr_fire  = st.aw_got & st.w_got & ~st.bvalid;
    assign wv       = merge(32'h0, st.w_data, st.w_strb);

    // whole next state
    always_comb begin
        next_st = st;
        next_st.sync1 = pps_ref_in;
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        // local second generation
        if (st.ticks >= st.period - 32'h1) begin
            next_st.ticks    = 32'h0;
            next_st.have_ref = 1'b0;
            next_st.period   = TICKS;
            if (!st.have_ref && st.phase != PH_HOLD) begin
                next_st.phase      = PH_HOLD;
                next_st.pulse_lock = 1'b0;
            end
        end else begin
            next_st.ticks = st.ticks + 32'h1;
        end
        next_st.pps_out = (st.ticks < PULSE_CYC);
        // capture on reference edge
        if (ref_edge) begin
            next_st.delta    = err_now;
            next_st.have_ref = 1'b1;
            if (steer_ok) begin
                case (st.phase)
                    PH_HOLD: next_st.phase = PH_JAM;
                    PH_JAM: begin
                        next_st.ticks = 32'h1;                       // jam phase to reference
                        next_st.phase = PH_DISC;  // pre-jam error must not steer
                    end
                    default: next_st.phase = PH_CALC;
                endcase
            end
        end else begin
            case (st.phase)
                PH_CALC: next_st.phase = PH_UPD;
                PH_UPD: begin
                    // shift this second's end by the filtered error
                    next_st.period     = st.period + corr;
                    next_st.pulse_lock = ($signed(st.delta) < $signed(LOCK_WIN))
                                      && ($signed(st.delta) > -$signed(LOCK_WIN));
                    next_st.phase      = PH_DISC;
                end
                default: next_st.phase = st.phase;
            endcase
        end
        if (!atomic_lock)
            next_st.pulse_lock = 1'b0;
        // lock output
        next_st.lock_out = (st.mode == 2'h2) ? (atomic_lock & st.pulse_lock) : atomic_lock;
        // axi write channel, stands in for the serial command link
        next_st.awready = ~st.aw_got & ~st.awready;
        next_st.wready  = ~st.w_got & ~st.wready;
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
            next_st.awready = 1'b0;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_got  = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
            next_st.wready = 1'b0;
        end
        if (wr_fire) begin
            next_st.bvalid = 1'b1;
            next_st.bresp  = 2'b00;
            case (st.aw_addr)
                OFS_CTRL: if (st.w_strb[0]) next_st.mode = wv[1:0];
                OFS_DAMP: begin
                    if (wv[4:0] < DAMP_MIN && wv[31:5] == 27'h0)
                        next_st.damp = DAMP_MIN;
                    else if (wv > 32'(DAMP_MAX))
                        next_st.damp = DAMP_MAX;
                    else
                        next_st.damp = wv[4:0];
                end
                OFS_TAU: begin
                    if (wv < 32'(TAU_MIN) || wv > 32'(TAU_MAX)) begin
                        next_st.damp = DAMP_DEF;
                        next_st.tau  = TAU_DEF;
                    end else begin
                        next_st.tau = wv[16:0];
                    end
                end
                OFS_SAVE: if (wv[0]) begin
                    next_st.saved_damp = st.damp;
                    next_st.saved_tau  = st.tau;
                end
                OFS_DELTA, OFS_STATE: ;
                default: next_st.bresp = 2'b10;
            endcase
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
        end
        // axi read channel
        next_st.arready = ~st.arready & ~st.rvalid;
        if (s_axi_arvalid && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid  = 1'b1;
            next_st.rresp   = 2'b00;
            case (s_axi_araddr)
                OFS_CTRL:  next_st.rdata = {30'h0, st.mode};
                OFS_DAMP:  next_st.rdata = {27'h0, st.damp};
                OFS_TAU:   next_st.rdata = {15'h0, st.tau};
                OFS_DELTA: next_st.rdata = st.delta;
                OFS_STATE: next_st.rdata = {26'h0, st.pulse_lock, atomic_lock,
                                            state_code(st.phase)};
                OFS_SAVE:  next_st.rdata = 32'h0;
                default: begin
                    next_st.rdata = 32'h0;
                    next_st.rresp = 2'b10;
                end
            endcase
        end
        if (st.rvalid && s_axi_rready)
            next_st.rvalid = 1'b0;
    end

    // register everything; reset loads the default coefficients into working and kept sets
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st            <= '0;
            st.period     <= TICKS;
            st.phase      <= PH_HOLD;
            st.mode       <= MODE_DEF;
            st.damp       <= DAMP_DEF;
            st.tau        <= TAU_DEF;
            st.saved_damp <= DAMP_DEF;
            st.saved_tau  <= TAU_DEF;
        end else begin
            st <= next_st;
        end
    end

    assign pps_out       = st.pps_out;
    assign lock_out      = st.lock_out;
    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rresp   = st.rresp;
    assign s_axi_rdata   = st.rdata;

    property p_capture;
        @(posedge aclk) disable iff (!aresetn)
        ref_edge |=> st.delta == $past(err_now);
    endproperty
    a_capture: assert property (p_capture) else $error("delta not captured");

    property p_one_edge;
        @(posedge aclk) disable iff (!aresetn)
        ref_edge |=> !ref_edge;
    endproperty
    a_one_edge: assert property (p_one_edge) else $error("double capture");

    property p_damp_range;
        @(posedge aclk) disable iff (!aresetn)
        st.damp >= DAMP_MIN && st.damp <= DAMP_MAX;
    endproperty
    a_damp_range: assert property (p_damp_range) else $error("damping out of range");

    property p_tau_range;
        @(posedge aclk) disable iff (!aresetn)
        st.tau >= TAU_MIN && st.tau <= TAU_MAX;
    endproperty
    a_tau_range: assert property (p_tau_range) else $error("tau out of range");

    property p_lock_mode;
        @(posedge aclk) disable iff (!aresetn)
        (st.mode != 2'h2) ##1 1'b1 |-> lock_out == $past(atomic_lock);
    endproperty
    a_lock_mode: assert property (p_lock_mode) else $error("lock output wrong");

    property p_no_steer;
        @(posedge aclk) disable iff (!aresetn)
        (ref_edge && !steer_ok) |=> st.phase == $past(st.phase);
    endproperty
    a_no_steer: assert property (p_no_steer) else $error("steered while barred");

    property p_restart;
        @(posedge aclk) disable iff (!aresetn)
        (st.ticks >= st.period - 32'h1 && !ref_edge) |=> st.ticks == 32'h0;
    endproperty
    a_restart: assert property (p_restart) else $error("counter not restarted");

    property p_read_delta;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && st.arready && s_axi_araddr == OFS_DELTA)
            |=> s_axi_rvalid && s_axi_rdata == $past(st.delta);
    endproperty
    a_read_delta: assert property (p_read_delta) else $error("delta read wrong");

    property p_save;
        @(posedge aclk) disable iff (!aresetn)
        (wr_fire && st.aw_addr == OFS_SAVE && wv[0]) |=> st.saved_tau == $past(st.tau);
    endproperty
    a_save: assert property (p_save) else $error("coefficients not kept");
endmodule : ppd_discipline

/* verification/ppd_ref_src.sv */
// Purpose: free running reference pulse source, one pulse per period
// Assumes: period counted in aclk cycles, same nominal rate as the local pulse
// Notes:   line held low while disabled, as a driven source output would be
`timescale 1ns/100ps
module ppd_ref_src #(
    parameter int PERIOD = 1000, // cycles between pulses
    parameter int WIDTH  = 4     // pulse width, above the two cycle minimum
) (
    input  wire logic aclk,      // bench clock
    input  wire logic en,        // source running
    output logic      pps_ref    // reference pulse
);
    int cnt;

    // phase fixed by when en rises, never follows the local pulse
    always_ff @(posedge aclk) begin
        if (!en) begin
            cnt <= 0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
        end
    end

    // one pulse at each wrap of the count
    assign pps_ref = en && (cnt < WIDTH);
endmodule : ppd_ref_src

/* verification/pps_phase_discipline_tb.sv */
// Purpose: register level bench for the pulse discipline block
// Assumes: TICKS shortened to 1000 cycles per local second
// Notes:   deltas compared as differences so the synchronizer delay cancels
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module pps_phase_discipline_tb;
    import ppd_pkg::*;
    localparam int   T     = 1000;   // ticks per simulated second
    localparam int   LIMIT = 60000;  // cycle ceiling of the whole run
    localparam logic [31:0] DW [5] = '{32'h0, 32'h11, 32'h1, 32'h10, 32'h8};
    localparam logic [31:0] DE [5] = '{32'h1, 32'h10, 32'h1, 32'h10, 32'h8};
    logic        aclk = 1'b0, aresetn = 1'b0, ref_en = 1'b0, atomic_lock = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic        rready = 1'b0, pps_ref_in, pps_out, lock_out;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp;
    int          failures, checks_done, cyc;

    always #12.5 aclk = ~aclk;

    ppd_discipline #(.TICKS(T)) uut (
        .aclk(aclk), .aresetn(aresetn), .pps_ref_in(pps_ref_in),
        .atomic_lock(atomic_lock), .pps_out(pps_out), .lock_out(lock_out),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    ppd_ref_src #(.PERIOD(T), .WIDTH(4)) u_ref (
        .aclk(aclk), .en(ref_en), .pps_ref(pps_ref_in));

    task automatic final_report();
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    // hang guard, counted as a mismatch
    always @(posedge aclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            failures++;
            final_report();
        end
    end

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic put(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
    endtask : put

    task automatic expect_reg(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        `CHK(nm, e, d)
    endtask : expect_reg

    // restart the source k cycles after a local pulse edge
    task automatic start_ref(input int k);
        @(posedge aclk);
        ref_en <= 1'b0;
        @(posedge pps_out);
        repeat (k) @(posedge aclk);
        ref_en <= 1'b1;
    endtask : start_ref

    initial begin
        logic [31:0] d1, d2, v;
        logic [1:0]  r;
        time         t0, t1, t2;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        expect_reg("mode", OFS_CTRL, 32'(MODE_DEF));
        expect_reg("damping", OFS_DAMP, 32'(DAMP_DEF));
        expect_reg("tau", OFS_TAU, 32'(TAU_DEF));
        rd(OFS_STATE, v, r);
        `CHK("state", ST_HOLD, v[3:0])
        // no reference yet, so this is holdover timing
        @(posedge pps_out);
        t0 = $time;
        @(negedge pps_out);
        t1 = $time;
        @(posedge pps_out);
        t2 = $time;
        `CHK("pulse width", 64'(PULSE_CYC * 25), t1 - t0)
        `CHK("pulse period", 64'(T * 25), t2 - t0)
        wr(8'h18, 32'h1, r);
        `CHK("unmapped write", 2'b10, r)
        rd(8'h18, v, r);
        `CHK("unmapped read", 2'b10, r)
        for (int i = 0; i < 5; i++) begin
            put(OFS_DAMP, DW[i]);
            expect_reg("damping clamp", OFS_DAMP, DE[i]);
        end
        put(OFS_TAU, 32'd5);
        expect_reg("tau low", OFS_TAU, 32'd5);
        put(OFS_TAU, 32'd100000);
        expect_reg("tau high", OFS_TAU, 32'd100000);
        // both sides of the range restore both defaults
        for (int i = 0; i < 2; i++) begin
            put(OFS_DAMP, 32'd8);
            put(OFS_TAU, i ? 32'd100001 : 32'd4);
            expect_reg("tau default", OFS_TAU, 32'(TAU_DEF));
            expect_reg("damp default", OFS_DAMP, 32'(DAMP_DEF));
        end
        wr(OFS_SAVE, 32'h1, r);
        `CHK("save resp", 2'b00, r)
        put(OFS_TAU, 32'd5); // fastest loop, so steering shows in few seconds
        // atomic loop unlocked: pure capture, nothing steered
        start_ref(100);
        repeat (3 * T) @(posedge aclk);
        rd(OFS_DELTA, d1, r);
        repeat (T) @(posedge aclk);
        expect_reg("delta held", OFS_DELTA, d1);
        start_ref(150);
        repeat (3 * T) @(posedge aclk);
        rd(OFS_DELTA, v, r);
        `CHK("delta step", 32'd50, v - d1)
        start_ref(900);
        repeat (3 * T) @(posedge aclk);
        rd(OFS_DELTA, v, r);
        `CHK("delta wrap", 32'hffffff38, v - d1)
        // suspended mode first, before any steering has acted
        put(OFS_CTRL, 32'h1);
        atomic_lock <= 1'b1;
        repeat (4) @(posedge aclk);
        `CHK("lock mode 1", 1'b1, lock_out)
        rd(OFS_STATE, v, r);
        `CHK("atomic bit", 1'b1, v[4])
        rd(OFS_DELTA, d2, r);
        repeat (2 * T) @(posedge aclk);
        expect_reg("delta suspended", OFS_DELTA, d2);
        put(OFS_CTRL, 32'h0);
        repeat (4) @(posedge aclk);
        `CHK("lock mode 0", 1'b1, lock_out)
        put(OFS_CTRL, 32'h2);
        repeat (4) @(posedge aclk);
        `CHK("lock mode 2 far", 1'b0, lock_out)
        repeat (20 * T) @(posedge aclk);
        rd(OFS_DELTA, v, r);
        `CHK("delta steered", 32'h0, v)
        `CHK("lock mode 2 near", 1'b1, lock_out)
        rd(OFS_STATE, v, r);
        `CHK("pulse lock bit", 1'b1, v[5])
        `CHK("disciplining", 1'b1, v[3:0] inside {ST_DISC, ST_CALC, ST_UPD})
        atomic_lock <= 1'b0;
        repeat (4) @(posedge aclk);
        `CHK("lock lost", 1'b0, lock_out)
        final_report();
    end
endmodule : pps_phase_discipline_tb
